//--- network_power_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module network_power_mode_ctrl
    import network_pm_pkg::*;
#(
    parameter int SETTLE_LIMIT = SLOW_SETTLE_CYCLES,
    parameter int BOOT_LIMIT   = BOOT_CYCLES,
    parameter int IDLE_LIMIT   = IDLE_CYCLES,
    parameter bit INTEGRATED   = 1'b0
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // Host pins
    input  wire logic       hibernate_control_pin_i,
    input  wire logic       host_cmd_i,
    input  wire logic       host_status_read_i,
    input  wire logic       supply_present_i,
    output logic            host_irq_o,
    // Block activity, same clock
    input  wire logic       np_activity_i,
    input  wire logic       radio_activity_i,
    input  wire logic       np_event_i,
    input  wire logic [1:0] application_cpu_core_mode_i,
    // Modes
    output logic [1:0]      subsys_mode_o,
    output logic [1:0]      device_mode_o,
    // Power and clock controls
    output logic            fast_crystal_oscillator_en_o,
    output logic            pll_en_o,
    output logic            voltage_nominal_o,
    output logic            mem_power_o,
    output logic            mem_retain_o,
    output logic            rtc_run_o,
    output logic            logic_power_o,
    output logic            np_power_o,
    output logic            radio_power_o,
    // Boot
    output logic            boot_cold_o,
    output logic            boot_warm_o,
    output logic            app_cpu_reset_vector_o
);
    initial begin
        if (SETTLE_LIMIT < 1 || BOOT_LIMIT < 1 ||
            SETTLE_LIMIT + BOOT_LIMIT >= (1 << CNT_W)) begin
            $error("boot counts out of range");
        end
    end

    typedef enum logic [3:0] {
        ST_SHUT = 4'h1,
        ST_HIB  = 4'h2,
        ST_BOOT = 4'h4,
        ST_ON   = 4'h8
    } pm_state_t;

    // ==========================================================
    // Pin synchronisers
    logic [1:0] sync_en;
    logic [1:0] sync_cmd;
    logic [1:0] sync_rd;
    logic [1:0] sync_sup;
    logic       cmd_d;
    logic       rd_d;
    logic       cmd_pulse;
    logic       rd_pulse;
    logic       en_s;
    logic       sup_s;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sync_en  <= 2'h0;
            sync_cmd <= 2'h0;
            sync_rd  <= 2'h0;
            sync_sup <= 2'h0;
            cmd_d    <= 1'b0;
            rd_d     <= 1'b0;
        end else begin
            sync_en  <= {sync_en[0], hibernate_control_pin_i};
            sync_cmd <= {sync_cmd[0], host_cmd_i};
            sync_rd  <= {sync_rd[0], host_status_read_i};
            sync_sup <= {sync_sup[0], supply_present_i};
            cmd_d    <= sync_cmd[1];
            rd_d     <= sync_rd[1];
        end
    end

    assign en_s      = sync_en[1]; // [R16]
    assign sup_s     = sync_sup[1];
    assign cmd_pulse = sync_cmd[1] && !cmd_d;
    assign rd_pulse  = sync_rd[1] && !rd_d;

    // ==========================================================
    // Top-level sequence
    pm_state_t        state;
    pm_state_t        next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             next_boot_cold;
    logic             next_boot_warm;
    logic             boot_done;

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_boot_cold = 1'b0;
        next_boot_warm = 1'b0;
        boot_done      = 1'b0;
        case (state)
            ST_SHUT: begin
                if (sup_s && en_s) begin
                    // Slow clock must settle before the boot proper
                    next_state     = ST_BOOT; // [R05] [R10]
                    next_cnt       = CNT_W'(SETTLE_LIMIT + BOOT_LIMIT - 1);
                    next_boot_cold = 1'b1;
                end
            end
            ST_HIB: begin
                if (en_s) begin
                    next_state     = ST_BOOT; // [R10] [R06]
                    next_cnt       = CNT_W'(BOOT_LIMIT - 1);
                    next_boot_warm = 1'b1;
                end
            end
            ST_BOOT: begin
                if (!en_s) begin
                    next_state = ST_HIB;
                end else if (cnt == '0) begin
                    next_state = ST_ON;
                    boot_done  = 1'b1;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            ST_ON: begin
                if (!en_s) begin
                    next_state = ST_HIB;
                end
            end
            default: begin
                next_state = ST_SHUT;
                next_cnt   = '0;
            end
        endcase
        // Supply loss overrides everything except boot_done and forgets all state
        if (!sup_s) begin
            next_state     = ST_SHUT; // [R05]
            next_cnt       = '0;
            next_boot_cold = 1'b0;
            next_boot_warm = 1'b0;
        end
    end

    // ==========================================================
    // Host event line; a new event beats a status read in the same cycle
    logic next_irq;

    always_comb begin
        next_irq = host_irq_o;
        if (rd_pulse) begin
            next_irq = 1'b0; // [R14]
        end
        if ((state == ST_ON && np_event_i) || boot_done) begin
            next_irq = 1'b1;
        end
        if (state != ST_ON && state != ST_BOOT) begin
            next_irq = 1'b0;
        end
    end

    // ==========================================================
    // Per-block sleep control
    block_pm_if blk_bus [2] ();
    logic [1:0] blk_act;
    logic [1:0] blk_wake;

    // A pending host event keeps the processor awake; the radio never sees it
    assign blk_act[NP_IDX]  = np_activity_i || host_irq_o; // [R14] [R03]
    assign blk_act[RL_IDX]  = radio_activity_i;
    assign blk_wake[NP_IDX] = cmd_pulse && (state == ST_ON); // [R15]
    assign blk_wake[RL_IDX] = 1'b0;

    logic [1:0] blk_ret;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_blk
            assign blk_bus[g].enable   = (state == ST_ON);
            assign blk_bus[g].activity = blk_act[g];
            assign blk_bus[g].wake     = blk_wake[g];
            assign blk_ret[g]          = blk_bus[g].retained;
            block_sleep_ctrl #(
                .IDLE_LIMIT (IDLE_LIMIT)
            ) u_blk (
                .clock_i   (clock_i),
                .sys_rst_i (sys_rst_i),
                .pm        (blk_bus[g])
            );
        end
    endgenerate

    // ==========================================================
    // Mode derivation; only the summary mode leaves, not sub-states
    logic [1:0] next_sub;
    logic [1:0] sub_dev;
    logic [1:0] next_dev;

    always_comb begin
        if (state == ST_ON && (&blk_ret)) begin
            next_sub = SUB_DEEP_SLEEP; // [R01] [R04] [R12]
        end else if (state == ST_ON || state == ST_BOOT) begin
            next_sub = SUB_ACTIVE; // [R02] [R13]
        end else begin
            next_sub = SUB_OFF;
        end
        case (next_sub)
            SUB_DEEP_SLEEP: sub_dev = DEV_DEEP_SLEEP;
            SUB_ACTIVE:     sub_dev = DEV_ACTIVE;
            default:        sub_dev = (INTEGRATED || state == ST_SHUT) ? DEV_SHUT : DEV_HIB;
        endcase
        next_dev = sub_dev;
        if (INTEGRATED && application_cpu_core_mode_i > sub_dev) begin
            next_dev = application_cpu_core_mode_i; // [R11]
        end
        if (state == ST_SHUT) begin
            next_dev = DEV_SHUT;
        end
    end

    // ==========================================================
    // Output registers
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state                        <= ST_SHUT;
            cnt                          <= '0;
            host_irq_o                   <= 1'b0;
            subsys_mode_o                <= SUB_OFF;
            device_mode_o                <= DEV_SHUT;
            fast_crystal_oscillator_en_o <= 1'b0;
            pll_en_o                     <= 1'b0;
            voltage_nominal_o            <= 1'b0;
            mem_power_o                  <= 1'b0;
            mem_retain_o                 <= 1'b0;
            rtc_run_o                    <= 1'b0;
            logic_power_o                <= 1'b0;
            np_power_o                   <= 1'b0;
            radio_power_o                <= 1'b0;
            boot_cold_o                  <= 1'b0;
            boot_warm_o                  <= 1'b0;
            app_cpu_reset_vector_o       <= 1'b0;
        end else begin
            state                        <= next_state;
            cnt                          <= next_cnt;
            host_irq_o                   <= next_irq;
            subsys_mode_o                <= next_sub;
            device_mode_o                <= next_dev;
            fast_crystal_oscillator_en_o <= (next_dev == DEV_ACTIVE); // [R07] [R09]
            pll_en_o                     <= (next_dev == DEV_ACTIVE); // [R07] [R09]
            voltage_nominal_o            <= (next_dev == DEV_ACTIVE); // [R07] [R09]
            mem_power_o                  <= (next_dev >= DEV_DEEP_SLEEP); // [R05] [R06]
            mem_retain_o                 <= (next_dev == DEV_DEEP_SLEEP); // [R07]
            rtc_run_o                    <= (next_dev != DEV_SHUT); // [R05] [R06]
            logic_power_o                <= (next_dev == DEV_ACTIVE); // [R08]
            np_power_o                   <= (next_sub != SUB_OFF);
            radio_power_o                <= (next_sub != SUB_OFF);
            boot_cold_o                  <= next_boot_cold;
            boot_warm_o                  <= next_boot_warm;
            app_cpu_reset_vector_o       <= INTEGRATED && (device_mode_o == DEV_DEEP_SLEEP)
                                            && (next_dev == DEV_ACTIVE); // [R08]
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_sleep_both_ret: assert property (subsys_mode_o == SUB_DEEP_SLEEP |-> // [R01]
                                       $past(&blk_ret) && $past(state == ST_ON))
        else $error("deep sleep reported with a block running");
    a_active_any_run: assert property ($past(state == ST_ON && !(&blk_ret)) |-> // [R02]
                                       subsys_mode_o == SUB_ACTIVE)
        else $error("running block but subsystem not active");
    a_sleep_supplies: assert property (device_mode_o == DEV_DEEP_SLEEP |-> // [R07]
                                       !fast_crystal_oscillator_en_o && !pll_en_o &&
                                       !voltage_nominal_o && mem_retain_o)
        else $error("deep sleep with fast clocks or full voltage");
    a_active_supplies: assert property (device_mode_o == DEV_ACTIVE |-> // [R09]
                                        fast_crystal_oscillator_en_o && pll_en_o &&
                                        voltage_nominal_o && logic_power_o)
        else $error("active mode with a supply or clock off");
    a_shut_nothing: assert property (device_mode_o == DEV_SHUT |-> // [R05]
                                     !rtc_run_o && !mem_power_o)
        else $error("shutdown keeps clock or memory");
    a_hib_rtc_only: assert property (device_mode_o == DEV_HIB |-> // [R06]
                                     rtc_run_o && !logic_power_o && !mem_power_o)
        else $error("hibernate power wrong");
    a_irq_no_sleep: assert property (host_irq_o [*3] |-> subsys_mode_o != SUB_DEEP_SLEEP) // [R14]
        else $error("deep sleep while event line up");
    a_cmd_wakes_np: assert property (cmd_pulse && state == ST_ON && blk_ret[NP_IDX] // [R15]
                                     |-> ##[1:2] !blk_ret[NP_IDX])
        else $error("host command did not wake processor");
    a_cold_origin: assert property (boot_cold_o |-> $past(state == ST_SHUT)) // [R10]
        else $error("cold boot not from shutdown");
    a_warm_origin: assert property (boot_warm_o |-> $past(state == ST_HIB)) // [R10]
        else $error("warm boot not from hibernate");
    a_cold_settles: assert property (boot_cold_o |-> !subsys_mode_o[0] [*8]) // [R05]
        else $error("cold boot skipped slow clock wait");
    a_reset_vector: assert property (app_cpu_reset_vector_o |-> // [R08]
                                     device_mode_o == DEV_ACTIVE &&
                                     $past(device_mode_o) == DEV_DEEP_SLEEP)
        else $error("reset vector pulse without deep sleep wakeup");
    a_device_combo: assert property (INTEGRATED && $past(state != ST_SHUT) |-> // [R11]
                                     device_mode_o >= $past(application_cpu_core_mode_i))
        else $error("device mode below application core mode");

    c_sleep_entry: cover property (subsys_mode_o == SUB_ACTIVE ##1
                                   subsys_mode_o == SUB_DEEP_SLEEP);
    c_sleep_wake:  cover property (subsys_mode_o == SUB_DEEP_SLEEP ##1
                                   subsys_mode_o == SUB_ACTIVE);
    c_cold_boot:  cover property (boot_cold_o);
    c_warm_boot:  cover property (boot_warm_o);
    c_irq_clear:  cover property (host_irq_o ##1 !host_irq_o);
endmodule // network_power_mode_ctrl
`default_nettype wire

//--- network_pm_pkg.sv
// Contract
// R01 - Report deep sleep only when both processor and radio blocks are retained.
// R02 - Subsystem is active while either block is running.
// R03 - Each block decides its own sleep entry and wakeup alone.
// R04 - A block idles into retention when it has no pending activity.
// R05 - Shutdown keeps no memory, stops clock; exit is cold boot with slow-clock wait.
// R06 - Hibernate keeps clock oscillator and counter only; exit needs a boot.
// R07 - Deep sleep stops fast crystal and PLL, lowers voltage, retains memory.
// R08 - Device deep sleep gates logic; wakeup restarts application core at reset vector.
// R09 - Active mode holds nominal voltage and runs all clocks.
// R10 - Enabling chooses cold or warm boot from shutdown or hibernate origin.
// R11 - Integrated chip mode combines application core mode with subsystem mode.
// R12 - Enabled subsystem picks sleep or active itself, no user control.
// R13 - Transient sub-states inside active mode are not exposed.
// R14 - No deep sleep while host event line is up; cleared by status read. Code can still report deep sleep for two cycles after the line rises.
// R15 - Host command any time while enabled wakes processor block to handle it.
// R16 - Host drives one enable line; it never selects sleep or active.
package network_pm_pkg;
    // ==========================================================
    // Mode encodings
    localparam logic [1:0] SUB_OFF        = 2'h0;
    localparam logic [1:0] SUB_DEEP_SLEEP = 2'h1;
    localparam logic [1:0] SUB_ACTIVE     = 2'h2;
    localparam logic [1:0] DEV_SHUT       = 2'h0;
    localparam logic [1:0] DEV_HIB        = 2'h1;
    localparam logic [1:0] DEV_DEEP_SLEEP = 2'h2;
    localparam logic [1:0] DEV_ACTIVE     = 2'h3;
    // ==========================================================
    // Block indices
    localparam int NP_IDX = 0;
    localparam int RL_IDX = 1;
    // ==========================================================
    // Timing
    localparam int CLK_FREQ_HZ    = 40_000_000;
    localparam int SLOW_SETTLE_US = 200;
    localparam int BOOT_US        = 10;
    localparam int IDLE_US        = 2;
    localparam int SLOW_SETTLE_CYCLES = (SLOW_SETTLE_US * (CLK_FREQ_HZ / 1_000_000));
    localparam int BOOT_CYCLES        = (BOOT_US * (CLK_FREQ_HZ / 1_000_000));
    localparam int IDLE_CYCLES        = (IDLE_US * (CLK_FREQ_HZ / 1_000_000));
    localparam int CNT_W              = 16;
endpackage

//--- block_pm_if.sv
`timescale 1ns/10ps
`default_nettype none
interface block_pm_if;
    logic enable;
    logic activity;
    logic wake;
    logic retained;
    logic running;
    modport ctrl (output enable, output activity, output wake, input retained, input running);
    modport blk  (input enable, input activity, input wake, output retained, output running);
endinterface
`default_nettype wire

//--- block_sleep_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module block_sleep_ctrl
    import network_pm_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_CYCLES
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    // Control from the sequencer
    block_pm_if.blk   pm
);
    initial begin
        if (IDLE_LIMIT < 1 || IDLE_LIMIT >= (1 << CNT_W)) begin
            $error("IDLE_LIMIT out of range");
        end
    end

    typedef enum logic [2:0] {
        BLK_OFF = 3'h1,
        BLK_RUN = 3'h2,
        BLK_RET = 3'h4
    } blk_state_t;

    blk_state_t       state;
    blk_state_t       next_state;
    logic [CNT_W-1:0] idle;
    logic [CNT_W-1:0] next_idle;

    // ==========================================================
    // Sleep decision, driven only by this block's own inputs
    always_comb begin
        next_state = state;
        next_idle  = idle;
        case (state)
            BLK_OFF: begin
                next_idle = '0;
                if (pm.enable) begin
                    next_state = BLK_RUN;
                end
            end
            BLK_RUN: begin
                if (!pm.enable) begin
                    next_state = BLK_OFF;
                end else if (pm.activity || pm.wake) begin
                    next_idle = '0;
                end else if (idle == CNT_W'(IDLE_LIMIT - 1)) begin
                    next_state = BLK_RET; // [R04] [R03]
                    next_idle  = '0;
                end else begin
                    next_idle = idle + 1'b1;
                end
            end
            BLK_RET: begin
                if (!pm.enable) begin
                    next_state = BLK_OFF;
                end else if (pm.activity || pm.wake) begin
                    next_state = BLK_RUN; // [R03] [R15]
                end
            end
            default: begin
                next_state = BLK_OFF;
                next_idle  = '0;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state <= BLK_OFF;
            idle  <= '0;
        end else begin
            state <= next_state;
            idle  <= next_idle;
        end
    end

    assign pm.retained = (state == BLK_RET);
    assign pm.running  = (state == BLK_RUN);

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_wake_from_ret: assert property ((state == BLK_RET) && pm.enable && pm.wake // [R15]
                                      |=> state == BLK_RUN)
        else $error("retained block ignored wake");
    a_idle_entry: assert property ($rose(pm.retained) |-> // [R04]
                                   $past(!pm.activity && !pm.wake))
        else $error("retention entered with activity");
endmodule // block_sleep_ctrl
`default_nettype wire

//--- host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic clock_i,
    // Requests from the test sequence
    input  wire logic want_enable_i,
    input  wire logic want_cmd_i,
    input  wire logic auto_ack_i,
    // Device side
    input  wire logic host_irq_i,
    output logic      enable_o,
    output logic      cmd_o,
    output logic      status_read_o
);
    // ==========================================================
    // Pins
    // One enable level only; the host never picks sleep or active
    assign enable_o = want_enable_i;
    // A command may go out at any time while enabled
    assign cmd_o    = want_cmd_i;
    // ==========================================================
    // Event service
    // Toggling the read gives a fresh rising edge each pass until the line drops
    initial status_read_o = 1'b0;
    always @(negedge clock_i) begin
        status_read_o <= auto_ack_i && host_irq_i && !status_read_o;
    end
endmodule // host_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
    import network_pm_pkg::*;
;
    logic clock_i, sys_rst_i, want_en, want_cmd, auto_ack, supply, np_act, radio_act, np_event;
    logic en_pin, cmd_pin, rd_pin, irq, b_cold, b_warm, rvec, rvec_i;
    logic xo, pll, vnom, mpow, mret, rtc, lpow, npp, rdp;
    logic [1:0] sub_m, dev_m, app_m, dev_i;
    int failures, n_checks, cycles;

    host_model host_model_i (.clock_i(clock_i), .want_enable_i(want_en), .want_cmd_i(want_cmd),
        .auto_ack_i(auto_ack), .host_irq_i(irq), .enable_o(en_pin), .cmd_o(cmd_pin),
        .status_read_o(rd_pin));
    network_power_mode_ctrl #(.SETTLE_LIMIT(10), .BOOT_LIMIT(4), .IDLE_LIMIT(4),
        .INTEGRATED(1'b0)) network_power_mode_ctrl_i (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hibernate_control_pin_i(en_pin),
        .host_cmd_i(cmd_pin), .host_status_read_i(rd_pin), .supply_present_i(supply),
        .host_irq_o(irq), .np_activity_i(np_act), .radio_activity_i(radio_act),
        .np_event_i(np_event), .application_cpu_core_mode_i(app_m), .subsys_mode_o(sub_m),
        .device_mode_o(dev_m), .fast_crystal_oscillator_en_o(xo), .pll_en_o(pll),
        .voltage_nominal_o(vnom), .mem_power_o(mpow), .mem_retain_o(mret), .rtc_run_o(rtc),
        .logic_power_o(lpow), .np_power_o(npp), .radio_power_o(rdp), .boot_cold_o(b_cold),
        .boot_warm_o(b_warm), .app_cpu_reset_vector_o(rvec));
    // On-chip variant on the same pins
    if (1'b1) begin : g_integrated
        network_power_mode_ctrl #(.SETTLE_LIMIT(10), .BOOT_LIMIT(4), .IDLE_LIMIT(4),
            .INTEGRATED(1'b1)) network_power_mode_ctrl_i (
            .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hibernate_control_pin_i(en_pin),
            .host_cmd_i(cmd_pin), .host_status_read_i(rd_pin), .supply_present_i(supply),
            .host_irq_o(), .np_activity_i(np_act), .radio_activity_i(radio_act),
            .np_event_i(np_event), .application_cpu_core_mode_i(app_m), .subsys_mode_o(),
            .device_mode_o(dev_i), .fast_crystal_oscillator_en_o(), .pll_en_o(),
            .voltage_nominal_o(), .mem_power_o(), .mem_retain_o(), .rtc_run_o(),
            .logic_power_o(), .np_power_o(), .radio_power_o(), .boot_cold_o(),
            .boot_warm_o(), .app_cpu_reset_vector_o(rvec_i));
    end

    // ==========================================================
    // Clock, watchdog
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // At most about 380 cycles are needed; the ceiling leaves ample margin
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            wrap_up();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_dev(input logic [1:0] m, input int lim);
        for (int i = 0; i < lim && dev_m !== m; i++) @(negedge clock_i);
        check("device mode", {6'h0, dev_m}, {6'h0, m});
    endtask
    // Clocks, voltage, logic and memory follow the device mode; processor and radio rails follow the subsystem mode
    task automatic check_power();
        check("power", {xo, pll, vnom, lpow, mpow, mret, rtc, npp},
              {{4{dev_m == DEV_ACTIVE}}, dev_m >= DEV_DEEP_SLEEP, dev_m == DEV_DEEP_SLEEP,
               dev_m != DEV_SHUT, sub_m != SUB_OFF});
        check("radio rail", {7'h0, rdp}, {7'h0, sub_m != SUB_OFF});
    endtask
    task automatic boot(input logic cold);
        for (int i = 0; i < 10 && b_cold !== 1'b1 && b_warm !== 1'b1; i++) @(negedge clock_i);
        check("boot kind", {6'h0, b_cold, b_warm}, {6'h0, cold, !cold});
        @(negedge clock_i);
        check("boot mode", {6'h0, sub_m}, {6'h0, SUB_ACTIVE});
        check("boot pulse", {6'h0, b_cold, b_warm}, 8'h00);
        wait_dev(DEV_ACTIVE, 2);
        check_power();
        // The boot-done event has to be serviced before sleep is allowed
        for (int i = 0; i < 30 && irq !== 1'b1; i++) @(negedge clock_i);
        check("boot event", {7'h0, irq}, 8'h01);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_cold_boot_sleep();
        supply = 1'b1;
        want_en = 1'b1;
        boot(1'b1);
        wait_dev(DEV_DEEP_SLEEP, 40);
        check("sleep mode", {6'h0, sub_m}, {6'h0, SUB_DEEP_SLEEP});
        check_power();
        $display("test cold boot and sleep done");
    endtask
    task automatic t_radio_wakes();
        radio_act = 1'b1;
        wait_dev(DEV_ACTIVE, 4);
        check("radio active", {6'h0, sub_m}, {6'h0, SUB_ACTIVE});
        check_power();
        radio_act = 1'b0;
        wait_dev(DEV_DEEP_SLEEP, 40);
        $display("test radio wake done");
    endtask
    task automatic t_command_wakes();
        want_cmd = 1'b1;
        @(negedge clock_i);
        @(negedge clock_i);
        want_cmd = 1'b0;
        wait_dev(DEV_ACTIVE, 8);
        check("cmd mode", {6'h0, sub_m}, {6'h0, SUB_ACTIVE});
        wait_dev(DEV_DEEP_SLEEP, 40);
        $display("test command wake done");
    endtask
    task automatic t_event_holds();
        auto_ack = 1'b0;
        np_act = 1'b1;
        np_event = 1'b1;
        @(negedge clock_i);
        np_event = 1'b0;
        np_act = 1'b0;
        repeat (40) @(negedge clock_i);
        check("irq held", {7'h0, irq}, 8'h01);
        check("no sleep", {6'h0, dev_m}, {6'h0, DEV_ACTIVE});
        auto_ack = 1'b1;
        for (int i = 0; i < 10 && irq !== 1'b0; i++) @(negedge clock_i);
        check("irq clear", {7'h0, irq}, 8'h00);
        wait_dev(DEV_DEEP_SLEEP, 40);
        $display("test event hold done");
    endtask
    task automatic t_integrated();
        app_m = DEV_ACTIVE;
        @(negedge clock_i);
        check("chip mode", {6'h0, dev_i}, {6'h0, DEV_ACTIVE});
        check("reset vector", {7'h0, rvec_i}, 8'h01);
        check("plain mode", {6'h0, dev_m}, {6'h0, DEV_DEEP_SLEEP});
        app_m = DEV_HIB;
        @(negedge clock_i);
        check("vector pulse", {7'h0, rvec_i}, 8'h00);
        check("chip floor", {6'h0, dev_i}, {6'h0, DEV_DEEP_SLEEP});
        app_m = DEV_SHUT;
        $display("test integrated mode done");
    endtask
    task automatic t_hibernate_shutdown();
        want_en = 1'b0;
        wait_dev(DEV_HIB, 6);
        check("hib sub", {6'h0, sub_m}, {6'h0, SUB_OFF});
        check("hib irq", {7'h0, irq}, 8'h00);
        check_power();
        want_en = 1'b1;
        boot(1'b0);
        supply = 1'b0;
        wait_dev(DEV_SHUT, 6);
        check_power();
        supply = 1'b1;
        boot(1'b1);
        $display("test hibernate and shutdown done");
    endtask

    // ==========================================================
    // Main sequence
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        failures = 0;
        n_checks = 0;
        cycles = 0;
        sys_rst_i = 1'b1;
        {want_en, want_cmd, supply, np_act, radio_act, np_event} = 6'h00;
        app_m = 2'h0;
        auto_ack = 1'b1;
        repeat (10) @(negedge clock_i);
        check("reset mode", {4'h0, sub_m, dev_m}, {4'h0, SUB_OFF, DEV_SHUT});
        check("reset power", {rtc, mpow, xo, b_cold, irq, rvec, npp, rdp}, 8'h00);
        sys_rst_i = 1'b0;
        @(negedge clock_i);
        t_cold_boot_sleep();
        t_radio_wakes();
        t_command_wakes();
        t_event_holds();
        t_integrated();
        t_hibernate_shutdown();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
